// *** rtl/icfg_regs.sv ***
/*
  Page 0 upper register bank for the imager front end: loop integration divisor, convergence
  flags, sample timing, test pattern control and page select, reached over AXI4-Lite.
  Assumes the gain loop and converters are outside; the external run pin is asynchronous.
*/
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module icfg_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic loop_run_pin,
  input wire logic loop_done,
  input wire logic [5:0] loop_conv_err,
  input wire logic phase_tick,
  input wire logic pix_start,
  input wire logic line_start,
  input wire logic pix_valid,
  input wire logic [9:0] adc_r,
  input wire logic [9:0] adc_g,
  input wire logic [9:0] adc_b,
  output logic loop_active,
  output logic [7:0] offset_int_divisor,
  output logic page_delay_sel,
  output logic sample_pulse,
  output logic [9:0] out_r,
  output logic [9:0] out_g,
  output logic [9:0] out_b
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] int_q;
  logic [7:0] flags_q;
  logic [7:0] rsvd_a_q;
  logic [7:0] rsvd_b_q;
  logic [7:0] edge_q;
  logic [7:0] wid_q;
  logic [7:0] pat_ctl_q;
  logic [7:0] fix_hi_q;
  logic [7:0] fix_lo_q;
  logic [7:0] pitch_q;
  logic [7:0] step_q;
  logic [7:0] dly_q;
  logic [7:0] spare_q;
  logic [7:0] page_q;
  logic [7:0] loop_ctl_q;
  logic active_q;
  logic pin_s1_q;
  logic pin_s2_q;

  // ----------------------------------------------------------------
  // bus handshake state
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic do_write;
  logic do_read;
  logic [7:0] wa;
  logic [7:0] wd;
  logic we;
  logic w_hit;
  logic r_hit;
  logic [7:0] rd_val;
  logic run_start;
  logic pin_enabled;
  logic [9:0] pat_r;
  logic [9:0] pat_g;
  logic [9:0] pat_b;
  logic pat_on;

  function automatic logic icfg_mapped(input logic [7:0] a);
    icfg_mapped = (a[1:0] == 2'h0) && (a[7:2] >= icfg_pkg::OFS_LOOP_INT[5:0] ||
      a[7:2] == icfg_pkg::OFS_LOOP_CTL[5:0]);
  endfunction : icfg_mapped

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wa = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wd = w_held_q ? w_data_q : s_axi_wdata[7:0];
  assign we = w_held_q ? w_strb_q : s_axi_wstrb[0];
  assign do_write = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !bvalid_q;
  assign w_hit = do_write && icfg_mapped(wa);

  // capture address and data until both present
  always_ff @(posedge aclk)
  begin
    if (!aresetn || do_write)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
    end
  end

  // write response, slave error on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= w_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_q <= icfg_pkg::RST_ZERO;
      rsvd_a_q <= icfg_pkg::RST_RSVD_A;
      rsvd_b_q <= icfg_pkg::RST_RSVD_B;
      edge_q <= icfg_pkg::RST_EDGE_POS;
      wid_q <= icfg_pkg::RST_PULSE_WID;
      pat_ctl_q <= icfg_pkg::RST_ZERO;
      fix_hi_q <= icfg_pkg::RST_ZERO;
      fix_lo_q <= icfg_pkg::RST_ZERO;
      pitch_q <= icfg_pkg::RST_ZERO;
      step_q <= icfg_pkg::RST_ZERO;
      dly_q <= icfg_pkg::RST_ZERO;
      spare_q <= icfg_pkg::RST_ZERO;
      page_q <= icfg_pkg::PAGE_ZERO;
      loop_ctl_q <= icfg_pkg::RST_ZERO;
    end
    else
    begin
      if (w_hit && we)
      begin
        unique case ({2'h0, wa[7:2]})
          icfg_pkg::OFS_LOOP_INT: int_q <= wd;
          icfg_pkg::OFS_RSVD_A: rsvd_a_q <= wd;
          icfg_pkg::OFS_RSVD_B: rsvd_b_q <= wd;
          icfg_pkg::OFS_EDGE_POS: edge_q <= wd;
          icfg_pkg::OFS_PULSE_WID: wid_q <= wd;
          icfg_pkg::OFS_PAT_CTL: pat_ctl_q <= wd;
          icfg_pkg::OFS_FIX_HI: fix_hi_q <= wd;
          icfg_pkg::OFS_FIX_LO: fix_lo_q <= wd;
          icfg_pkg::OFS_PITCH: pitch_q <= wd;
          icfg_pkg::OFS_STEP: step_q <= wd;
          icfg_pkg::OFS_LINE_DLY: dly_q <= wd;
          icfg_pkg::OFS_SPARE: spare_q <= wd;
          icfg_pkg::OFS_PAGE: page_q <= wd;
          icfg_pkg::OFS_LOOP_CTL: loop_ctl_q <= wd;
          default: ; // status register ignores writes
        endcase
      end
      if (loop_done)
        loop_ctl_q[icfg_pkg::LOOP_RUN_BIT] <= 1'b0; // run bit back to ready
    end
  end

  // ----------------------------------------------------------------
  // gain loop run and convergence flags
  // ----------------------------------------------------------------
  assign pin_enabled = !loop_ctl_q[icfg_pkg::LOOP_PIN_DIS_BIT];
  assign run_start = (w_hit && we && wa[7:2] == icfg_pkg::OFS_LOOP_CTL[5:0]
    && wd[icfg_pkg::LOOP_RUN_BIT]) || (pin_enabled && pin_s2_q);

  // pin synchroniser, loop activity, flags held between runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      active_q <= 1'b0;
      flags_q <= icfg_pkg::RST_ZERO;
    end
    else
    begin
      pin_s1_q <= loop_run_pin;
      pin_s2_q <= pin_s1_q;
      if (run_start)
        active_q <= 1'b1;
      else if (loop_done)
        active_q <= 1'b0;
      if (loop_done && active_q)
        flags_q <= {2'h0, loop_conv_err};
    end
  end

  // divisor 2^(code+1); reserved code leaves the divisor at zero
  assign offset_int_divisor = (int_q[icfg_pkg::INT_DIV_MSB:0] == icfg_pkg::INT_DIV_RSVD) ? 8'h00
    : 8'(8'h02 << int_q[icfg_pkg::INT_DIV_MSB:0]);
  assign loop_active = active_q;
  assign page_delay_sel = (page_q == icfg_pkg::PAGE_DELAY);

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  assign r_hit = icfg_mapped(s_axi_araddr);
  always_comb
  begin
    unique case ({2'h0, s_axi_araddr[7:2]})
      icfg_pkg::OFS_LOOP_INT: rd_val = int_q;
      icfg_pkg::OFS_CONV_FLAGS: rd_val = {2'h0, flags_q[5:0]};
      icfg_pkg::OFS_RSVD_A: rd_val = rsvd_a_q;
      icfg_pkg::OFS_RSVD_B: rd_val = rsvd_b_q;
      icfg_pkg::OFS_EDGE_POS: rd_val = edge_q;
      icfg_pkg::OFS_PULSE_WID: rd_val = wid_q;
      icfg_pkg::OFS_PAT_CTL: rd_val = pat_ctl_q;
      icfg_pkg::OFS_FIX_HI: rd_val = fix_hi_q;
      icfg_pkg::OFS_FIX_LO: rd_val = fix_lo_q;
      icfg_pkg::OFS_PITCH: rd_val = pitch_q;
      icfg_pkg::OFS_STEP: rd_val = step_q;
      icfg_pkg::OFS_LINE_DLY: rd_val = dly_q;
      icfg_pkg::OFS_SPARE: rd_val = spare_q;
      icfg_pkg::OFS_PAGE: rd_val = page_q;
      icfg_pkg::OFS_LOOP_CTL: rd_val = {loop_ctl_q[7:1], active_q};
      default: rd_val = 8'h00;
    endcase
  end

  // read data register, slave error on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end
    else if (do_read)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, r_hit ? rd_val : 8'h00};
      rresp_q <= r_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // sample timing and test pattern
  // ----------------------------------------------------------------
  icfg_sample_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase_tick(phase_tick),
    .pix_start(pix_start),
    .edge_pos(edge_q[icfg_pkg::EDGE_MSB:0]),
    .width_code(wid_q[7:icfg_pkg::WID_LSB]),
    .sample_pulse(sample_pulse)
  );

  icfg_pattern_gen u_pat (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_start(line_start),
    .pix_valid(pix_valid),
    .kind(pat_ctl_q[icfg_pkg::PAT_KIND_LSB+1:icfg_pkg::PAT_KIND_LSB]),
    .color_sel(pat_ctl_q[icfg_pkg::PAT_COLOR_LSB+1:icfg_pkg::PAT_COLOR_LSB]),
    .fixed_level({fix_hi_q, fix_lo_q[7:icfg_pkg::FIX_LO_LSB]}),
    .pitch(pitch_q),
    .step(step_q),
    .line_delay(dly_q[icfg_pkg::DLY_MSB:0]),
    .pat_r(pat_r),
    .pat_g(pat_g),
    .pat_b(pat_b)
  );

  assign pat_on = pat_ctl_q[icfg_pkg::PAT_SW_BIT];

  // output data register: converter data or pattern
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_r <= 10'h000;
      out_g <= 10'h000;
      out_b <= 10'h000;
    end
    else
    begin
      out_r <= pat_on ? pat_r : adc_r;
      out_g <= pat_on ? pat_g : adc_g;
      out_b <= pat_on ? pat_b : adc_b;
    end
  end

endmodule : icfg_regs

// *** rtl/icfg_pkg.sv ***
/*
  Package for the imager configuration block: register offsets, reset values, field positions
  and timing figures shared by the register bank and the pattern generator.
  Assumes a single 125 MHz clock and an AXI4-Lite master driving the register bank.
*/
package icfg_pkg;

  // ----------------------------------------------------------------
  // register indexes, byte address 4x
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOOP_INT = 8'h32;
  localparam logic [7:0] OFS_CONV_FLAGS = 8'h33;
  localparam logic [7:0] OFS_RSVD_A = 8'h34;
  localparam logic [7:0] OFS_RSVD_B = 8'h35;
  localparam logic [7:0] OFS_EDGE_POS = 8'h36;
  localparam logic [7:0] OFS_PULSE_WID = 8'h37;
  localparam logic [7:0] OFS_PAT_CTL = 8'h38;
  localparam logic [7:0] OFS_FIX_HI = 8'h39;
  localparam logic [7:0] OFS_FIX_LO = 8'h3A;
  localparam logic [7:0] OFS_PITCH = 8'h3B;
  localparam logic [7:0] OFS_STEP = 8'h3C;
  localparam logic [7:0] OFS_LINE_DLY = 8'h3D;
  localparam logic [7:0] OFS_SPARE = 8'h3E;
  localparam logic [7:0] OFS_PAGE = 8'h3F;
  localparam logic [7:0] OFS_LOOP_CTL = 8'h28;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RSVD_A = 8'h32;
  localparam logic [7:0] RST_RSVD_B = 8'h54;
  localparam logic [7:0] RST_EDGE_POS = 8'h1F;
  localparam logic [7:0] RST_PULSE_WID = 8'h60;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_DELAY = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INT_DIV_MSB = 2;
  localparam logic [2:0] INT_DIV_RSVD = 3'h7;
  localparam int EDGE_MSB = 4;
  localparam int WID_LSB = 5;
  localparam int PAT_SW_BIT = 7;
  localparam int PAT_KIND_LSB = 5;
  localparam int PAT_COLOR_LSB = 3;
  localparam int FIX_LO_LSB = 6;
  localparam int DLY_MSB = 3;
  localparam int LOOP_RUN_BIT = 0;
  localparam int LOOP_PIN_DIS_BIT = 4;
  localparam int NUM_CH = 6;
  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_FULL = 10'h3FF;

  // ----------------------------------------------------------------
  // pattern kinds and color choices
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PK_FIXED, PK_MAIN, PK_SUB, PK_GRID} icfg_kind_t;
  localparam logic [1:0] COL_ALL = 2'h0;
  localparam logic [1:0] COL_RED = 2'h1;
  localparam logic [1:0] COL_GREEN = 2'h2;
  localparam logic [1:0] COL_BLUE = 2'h3;

  // ----------------------------------------------------------------
  // timing: 32 phase slots per pixel period
  // ----------------------------------------------------------------
  localparam int PHASES = 32;
  localparam int GRID_SHIFT = 4;
  localparam int MAX_DLY = 15;

endpackage : icfg_pkg

// *** rtl/icfg_sample_timer.sv ***
/*
  Sample pulse timer: splits each pixel period into 32 slots and places the sample pulse.
  Assumes phase_tick is a one-cycle enable at 32 times the pixel rate, pix_start marks slot 0.
*/
`timescale 1ns/1ps
module icfg_sample_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic phase_tick,
  input wire logic pix_start,
  input wire logic [4:0] edge_pos,
  input wire logic [2:0] width_code,
  output logic sample_pulse
);

  logic [4:0] slot_q;
  logic [4:0] slot_d;
  logic pulse_q;
  logic pulse_d;
  logic [5:0] rise_slot;
  logic [5:0] wid_slots;
  logic [5:0] since_rise;

  // ----------------------------------------------------------------
  // slot counter and pulse window
  // ----------------------------------------------------------------
  // width (2k+2)/32, falling edge at slot n, rising edge width earlier
  assign wid_slots = {2'h0, width_code, 1'b0} + 6'h02;
  assign rise_slot = {1'b0, edge_pos} - wid_slots;
  assign since_rise = {1'b0, slot_q} - rise_slot;
  assign slot_d = pix_start ? 5'h00 : (phase_tick ? slot_q + 5'h01 : slot_q);
  assign pulse_d = (since_rise[4:0] < wid_slots[4:0]) || (wid_slots[5] && !since_rise[5]);

  // register slot and pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_q <= 5'h00;
      pulse_q <= 1'b0;
    end
    else
    begin
      slot_q <= slot_d;
      pulse_q <= pulse_d;
    end
  end

  assign sample_pulse = pulse_q;

endmodule : icfg_sample_timer

// *** rtl/icfg_pattern_gen.sv ***
/*
  Test pattern generator: fixed code, main or sub scan gradation, or grid, with per-color
  selection and a red-green-blue line delay. Assumes line_start and pix_valid from pixel timing.
*/
`timescale 1ns/1ps
module icfg_pattern_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_start,
  input wire logic pix_valid,
  input wire logic [1:0] kind,
  input wire logic [1:0] color_sel,
  input wire logic [9:0] fixed_level,
  input wire logic [7:0] pitch,
  input wire logic [7:0] step,
  input wire logic [3:0] line_delay,
  output logic [9:0] pat_r,
  output logic [9:0] pat_g,
  output logic [9:0] pat_b
);

  logic [9:0] main_q;
  logic [7:0] mcnt_q;
  logic [9:0] line_hist_q [0:31]; // sub scan code per line, newest at 0
  logic [7:0] lcnt_q;
  logic [9:0] pix_q;
  logic [9:0] line_no_q;
  logic [4:0] dly_g;
  logic [4:0] dly_b;
  logic [9:0] r_q;
  logic [9:0] g_q;
  logic [9:0] b_q;
  logic [9:0] code_r;
  logic [9:0] code_g;
  logic [9:0] code_b;
  logic [9:0] grid_r;
  logic [9:0] grid_g;
  logic [9:0] grid_b;
  logic mwrap;
  logic lwrap;
  logic [9:0] line_no_g;
  logic [9:0] line_no_b;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] icfg_grid(input logic [9:0] px, input logic [9:0] ln);
    icfg_grid = (px[icfg_pkg::GRID_SHIFT-1:0] == 4'h0 || ln[icfg_pkg::GRID_SHIFT-1:0] == 4'h0)
      ? icfg_pkg::CODE_FULL : 10'h000;
  endfunction : icfg_grid

  function automatic logic [9:0] icfg_pick(input logic [1:0] k, input logic [9:0] fx,
    input logic [9:0] mn, input logic [9:0] sb, input logic [9:0] gd);
    unique case (k)
      icfg_pkg::PK_FIXED: icfg_pick = fx;
      icfg_pkg::PK_MAIN: icfg_pick = mn;
      icfg_pkg::PK_SUB: icfg_pick = sb;
      icfg_pkg::PK_GRID: icfg_pick = gd;
    endcase
  endfunction : icfg_pick

  // ----------------------------------------------------------------
  // pitch counters and delays
  // ----------------------------------------------------------------
  assign mwrap = (mcnt_q >= pitch);
  assign lwrap = (lcnt_q >= pitch);
  assign dly_g = {1'b0, line_delay};
  assign dly_b = {line_delay, 1'b0};
  assign line_no_g = line_no_q - {6'h00, line_delay};
  assign line_no_b = line_no_q - {5'h00, line_delay, 1'b0};
  assign grid_r = icfg_grid(pix_q, line_no_q);
  assign grid_g = icfg_grid(pix_q, line_no_g);
  assign grid_b = icfg_grid(pix_q, line_no_b);
  assign code_r = icfg_pick(kind, fixed_level, main_q, line_hist_q[0], grid_r);
  assign code_g = icfg_pick(kind, fixed_level, main_q, line_hist_q[dly_g], grid_g);
  assign code_b = icfg_pick(kind, fixed_level, main_q, line_hist_q[dly_b], grid_b);

  // main scan gradation and pixel position
  always_ff @(posedge aclk)
  begin
    if (!aresetn || line_start)
    begin
      main_q <= 10'h000;
      mcnt_q <= 8'h00;
      pix_q <= 10'h000;
    end
    else if (pix_valid)
    begin
      pix_q <= pix_q + 10'h001;
      mcnt_q <= mwrap ? 8'h00 : mcnt_q + 8'h01;
      if (mwrap)
        main_q <= main_q + {2'h0, step};
    end
  end

  // sub scan gradation with line history for the color delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lcnt_q <= 8'h00;
      line_no_q <= 10'h000;
      for (int i = 0; i < 32; i++)
        line_hist_q[i] <= 10'h000;
    end
    else if (line_start)
    begin
      lcnt_q <= lwrap ? 8'h00 : lcnt_q + 8'h01;
      line_no_q <= line_no_q + 10'h001;
      line_hist_q[0] <= lwrap ? line_hist_q[0] + {2'h0, step} : line_hist_q[0];
      for (int i = 1; i < 32; i++)
        line_hist_q[i] <= line_hist_q[i-1];
    end
  end

  // color selection, unselected colors at full code
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_q <= 10'h000;
      g_q <= 10'h000;
      b_q <= 10'h000;
    end
    else
    begin
      r_q <= (color_sel == icfg_pkg::COL_ALL || color_sel == icfg_pkg::COL_RED)
        ? code_r : icfg_pkg::CODE_FULL;
      g_q <= (color_sel == icfg_pkg::COL_ALL || color_sel == icfg_pkg::COL_GREEN)
        ? code_g : icfg_pkg::CODE_FULL;
      b_q <= (color_sel == icfg_pkg::COL_ALL || color_sel == icfg_pkg::COL_BLUE)
        ? code_b : icfg_pkg::CODE_FULL;
    end
  end

  assign pat_r = r_q;
  assign pat_g = g_q;
  assign pat_b = b_q;

endmodule : icfg_pattern_gen

// *** dv/icfg_chk.sv ***
/* checker: bus handshake and output relations of icfg_regs
   assumes it is bound to every icfg_regs instance */
`timescale 1ns/1ps
module icfg_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic loop_done,
  input wire logic loop_active,
  input wire logic [7:0] offset_int_divisor
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------
  // bus steps
  // ---------------------------------------------
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_flags;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hCC;
  endsequence
  AST_WR_ANSWER: assert property (wr_both |=> s_axi_bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_B_STALL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_FLAGS_TOP: assert property (rd_flags |=> s_axi_rdata[7:6] == 2'h0)
    else $error("status top bits set");
  AST_DIV_CODE: assert property (!offset_int_divisor[0] && $countones(offset_int_divisor) <= 1)
    else $error("divisor not a power of two");
  AST_LOOP_END: assert property (loop_active && loop_done |-> ##[1:2] !loop_active)
    else $error("loop not ended");
endmodule : icfg_chk

bind icfg_regs icfg_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .loop_done, .loop_active, .offset_int_divisor);

// *** dv/icfg_pix_src.sv ***
/* pixel timing source: 32 phase slots per pixel, 8 pixels per line
   assumes one phase slot per aclk cycle */
`timescale 1ns/1ps
module icfg_pix_src (
  input wire logic aclk,
  input wire logic aresetn,
  output logic phase_tick,
  output logic pix_start,
  output logic pix_valid,
  output logic line_start
);
  logic [7:0] cnt_q;
  // free slot counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  // phase tick on every cycle out of reset, other strobes from the slot count
  assign phase_tick = aresetn;
  assign pix_start = aresetn && cnt_q[4:0] == 5'h00;
  assign pix_valid = pix_start;
  assign line_start = aresetn && cnt_q == 8'h00;
endmodule : icfg_pix_src

// *** dv/testbench.sv ***
/* testbench: registers, pattern output, pulse width and loop flags of icfg_regs
   assumes icfg_pix_src supplies the pixel timing */
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic loop_run_pin = 1'b0, loop_done = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, offset_int_divisor, v, w;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] loop_conv_err = 6'h00;
  logic [9:0] adc_r = 10'h0, adc_g = 10'h0, adc_b = 10'h0, out_r, out_g, out_b, lvl;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic phase_tick, pix_start, line_start, pix_valid, loop_active, page_delay_sel;
  logic sample_pulse;
  int mismatches = 0, tests_run = 0, i, n;
  always #4 aclk = ~aclk;
  icfg_pix_src i_src (.aclk, .aresetn, .phase_tick, .pix_start, .pix_valid, .line_start);
  icfg_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .loop_run_pin, .loop_done, .loop_conv_err, .phase_tick,
    .pix_start, .line_start, .pix_valid, .adc_r, .adc_g, .adc_b, .loop_active,
    .offset_int_divisor, .page_delay_sel, .sample_pulse, .out_r, .out_g, .out_b);
  // ---------------------------------------------
  // compare, close, bus cycles
  // ---------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // register index to byte address: four times the index
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 99) begin mismatches++; test_done(); end
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 99) begin mismatches++; test_done(); end
    chk(s_axi_rdata, {24'h0, d});
    chk(s_axi_rresp, er);
  endtask : rd
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    v = 8'($urandom(32'h7CCF));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(icfg_pkg::OFS_LOOP_INT, 8'h00, 2'h0);
    rd(icfg_pkg::OFS_RSVD_A, 8'h32, 2'h0);
    rd(icfg_pkg::OFS_RSVD_B, 8'h54, 2'h0);
    rd(icfg_pkg::OFS_EDGE_POS, 8'h1F, 2'h0);
    rd(icfg_pkg::OFS_PULSE_WID, 8'h60, 2'h0);
    for (i = 8'h38; i <= 8'h3F; i++) if (i != 8'h3E) rd(i[7:0], 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h2);
    wr(icfg_pkg::OFS_CONV_FLAGS, 8'hFF, 2'h0);
    rd(icfg_pkg::OFS_CONV_FLAGS, 8'h00, 2'h0);
    // random readback, reserved and edge registers left alone
    for (i = 8'h38; i <= 8'h3D; i++)
    begin
      v = 8'($urandom);
      wr(i[7:0], v, 2'h0);
      rd(i[7:0], v, 2'h0);
    end
    for (i = 0; i < 8; i++)
    begin
      wr(icfg_pkg::OFS_LOOP_INT, i[7:0], 2'h0);
      chk(offset_int_divisor, i == 7 ? 8'h00 : 8'h02 << i);
    end
    wr(icfg_pkg::OFS_PAGE, icfg_pkg::PAGE_DELAY, 2'h0);
    chk(page_delay_sel, 1'b1);
    wr(icfg_pkg::OFS_PAGE, icfg_pkg::PAGE_ZERO, 2'h0);
    chk(page_delay_sel, 1'b0);
    // pattern switch off, then fixed code on each color choice
    adc_r <= 10'($urandom);
    adc_g <= 10'($urandom);
    adc_b <= 10'($urandom);
    wr(icfg_pkg::OFS_PAT_CTL, 8'h00, 2'h0);
    wr(icfg_pkg::OFS_LINE_DLY, 8'h00, 2'h0);
    chk({out_r, out_g, out_b}, {adc_r, adc_g, adc_b});
    v = 8'($urandom);
    w = 8'($urandom);
    lvl = {v, w[7:6]};
    wr(icfg_pkg::OFS_FIX_HI, v, 2'h0);
    wr(icfg_pkg::OFS_FIX_LO, w, 2'h0);
    for (i = 0; i < 4; i++)
    begin
      wr(icfg_pkg::OFS_PAT_CTL, {1'b1, icfg_pkg::PK_FIXED, i[1:0], 3'h0}, 2'h0);
      repeat (40) @(posedge aclk);
      chk(out_r, i < 2 ? lvl : 10'h3FF);
      chk(out_g, i == 0 || i == 2 ? lvl : 10'h3FF);
      chk(out_b, i == 0 || i == 3 ? lvl : 10'h3FF);
    end
    // pulse width over one pixel period
    for (i = 0; i < 8; i++)
    begin
      wr(icfg_pkg::OFS_PULSE_WID, {i[2:0], 5'h00}, 2'h0);
      repeat (64) @(posedge aclk);
      v = 8'h00;
      repeat (32) @(posedge aclk) v = v + 8'(sample_pulse);
      chk(v, 2 * i + 2);
    end
    // loop started by pin, flags latched at its end only
    loop_run_pin <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(loop_active, 1'b1);
    loop_run_pin <= 1'b0;
    repeat (5) @(posedge aclk);
    for (i = 0; i < 2; i++)
    begin
      loop_conv_err <= i == 0 ? 6'h2D : 6'h12;
      loop_done <= 1'b1;
      @(posedge aclk);
      loop_done <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(loop_active, 1'b0);
      rd(icfg_pkg::OFS_CONV_FLAGS, 8'h2D, 2'h0);
    end
    test_done();
  end
endmodule : testbench
